// ==== shared/wait_pkg.sv ====
package wait_pkg;

   // ------------------------------------------------------------
   // register map (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_SYS_WAIT   = 8'h00;
   localparam logic [7:0] ADDR_SERIAL_CTL = 8'h04;
   localparam logic [7:0] ADDR_SCKA_PER   = 8'h08;
   localparam logic [7:0] ADDR_STATUS     = 8'h0c;

   // ------------------------------------------------------------
   // fields and reset values
   // ------------------------------------------------------------
   localparam logic [7:0]  SYS_WAIT_RST   = 8'h77;
   localparam logic [2:0]  SYS_WAIT_ONE   = 3'h1;
   localparam int          CTL_SEL_LO_BIT = 0;
   localparam int          CTL_SEL_HI_BIT = 1;
   localparam int          CTL_CPU_MAIN   = 2;
   localparam int          CTL_RT_ENABLE  = 3;
   localparam logic [3:0]  SERIAL_CTL_RST = 4'h0;
   localparam int          FRAC_BITS      = 4;
   localparam logic [11:0] SCKA_PER_RST   = 12'h010;
   localparam int          STAT_BUSY_BIT  = 8;

   // ------------------------------------------------------------
   // wait arithmetic
   // ------------------------------------------------------------
   localparam int         SCKA_MULT     = 5;
   localparam int         CONT_OFFSET   = 4;
   localparam int         WAIT_BASE     = 2;
   localparam int         ACCESS_BASE   = 3;
   localparam logic [4:0] K_MAX_CONT    = 5'h12;
   localparam logic [4:0] K_MAX_CONFL   = 5'h14;
   localparam logic [6:0] WAIT_FIXED_1  = 7'h01;
   localparam logic [1:0] SEL_MAIN_DIV1 = 2'h0;

   // ------------------------------------------------------------
   // access classes presented by the cpu side
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      CLS_PLAIN,
      CLS_AUTO_SERIAL_BUF,
      CLS_TWO_WIRE_STATUS,
      CLS_UART_RX_STATUS,
      CLS_REALTIME_BUF
   } access_class_t;

endpackage

// ==== hdl/wait_factor_calc.sv ====
`timescale 1ns/10ps
`default_nettype none
module wait_factor_calc #(
   parameter int PERIOD_W = 12
) (
   input  wire logic [PERIOD_W-1:0] scka_period_in, // serial clock period, cpu clocks q.4
   input  wire logic                m_in,           // base peripheral wait
   input  wire logic                conflict_in,    // reception write collides
   output logic      [4:0]          k_out           // rounded, clamped factor
);
   localparam int NW = PERIOD_W + 4;

   logic [NW-1:0] five_p;
   logic [NW-1:0] offset;
   logic [NW-1:0] num;
   logic [NW-1:0] div;
   logic [NW-1:0] quo;
   logic [NW-1:0] rem;
   logic [NW-1:0] k_full;
   logic [NW-1:0] k_max;

   initial begin
      if (PERIOD_W < 5 || PERIOD_W > 24) begin
         $error("wait_factor_calc: PERIOD_W out of range");
      end
   end

   always_comb begin
      five_p = NW'(scka_period_in) * NW'(wait_pkg::SCKA_MULT);
      offset = NW'((wait_pkg::CONT_OFFSET + int'(m_in)) << wait_pkg::FRAC_BITS);
      div    = NW'((wait_pkg::WAIT_BASE + int'(m_in)) << wait_pkg::FRAC_BITS);
      // continuous writes subtract the cpu's own access time
      if (conflict_in) begin // see R06
         num   = five_p;
         k_max = NW'(wait_pkg::K_MAX_CONFL);
      end else begin // see R05
         num   = (five_p > offset) ? (five_p - offset) : '0;
         k_max = NW'(wait_pkg::K_MAX_CONT);
      end
      quo = num / div;
      rem = num % div;
      // fraction above 1/(2+m) of a unit counts whole
      k_full = quo + ((rem > NW'(1 << wait_pkg::FRAC_BITS)) ? NW'(1) : NW'(0)); // see R02
      k_out  = (k_full > k_max) ? k_max[4:0] : k_full[4:0];
   end
endmodule
`default_nettype wire

// ==== hdl/wait_down_counter.sv ====
`timescale 1ns/10ps
`default_nettype none
module wait_down_counter #(
   parameter int CNT_W = 7
) (
   input  wire logic             clk_in,   // cpu clock
   input  wire logic             rst_n_in, // synchronised reset
   input  wire logic             load_in,  // start of access
   input  wire logic [CNT_W-1:0] value_in, // cycles left after the start
   output logic                  busy_out, // access in progress
   output logic      [CNT_W-1:0] cnt_out,  // remaining count
   output logic                  done_out  // final cycle of access
);
   logic             busy_reg;
   logic [CNT_W-1:0] cnt_reg;

   initial begin
      if (CNT_W < 7) begin
         $error("wait_down_counter: CNT_W too small");
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         busy_reg <= 1'b0;
      end else if (load_in && !busy_reg) begin
         busy_reg <= 1'b1;
      end else if (busy_reg && cnt_reg == '0) begin
         busy_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt_reg <= '0;
      end else if (load_in && !busy_reg) begin
         cnt_reg <= value_in; // see R12
      end else if (busy_reg && cnt_reg != '0) begin
         cnt_reg <= cnt_reg - CNT_W'(1); // see R12
      end
   end

   assign busy_out = busy_reg;
   assign cnt_out  = cnt_reg;
   assign done_out = busy_reg && cnt_reg == '0;

   property p_count_step;
      @(posedge clk_in) disable iff (!rst_n_in)
         (busy_reg && cnt_reg != '0) |=> (busy_reg && cnt_reg == $past(cnt_reg) - CNT_W'(1));
   endproperty
   a_count_step: assert property (p_count_step) else $error("counter did not step down"); // see R12
endmodule
`default_nettype wire

// ==== hdl/peripheral_access_wait_inserter.sv ====
// Behaviour
// R01: m from low three wait-control bits
// R02: fraction above 1/(2+m) rounds up
// R03: listed waits are maxima; external fetch fewer
// R04: cpu avoids waited registers without main oscillator
// R05: serial buffer continuous write k 0..18
// R06: serial buffer write collision k 0..20
// R07: main clock, select 00: one wait
// R08: uart and two-wire status reads k=1
// R09: realtime buffer write k=1 when disabled
// R10: wait (2+m)k, access 3+m+(2+m)k
// R11: cpu held while waits run
// R12: counter loads, counts down, releases at zero
//
// Local design decisions: strobed register access and the address map.
`timescale 1ns/10ps
`default_nettype none
module peripheral_access_wait_inserter #(
   parameter int PERIOD_W = 12
) (
   input  wire logic                sys_clk_in,      // cpu clock, 20 MHz
   input  wire logic                arst_n_in,       // async reset, active low
   // register port
   input  wire logic [7:0]          reg_addr_in,     // byte address
   input  wire logic [31:0]         reg_wdata_in,    // write data
   input  wire logic                reg_wr_in,       // write strobe
   input  wire logic                reg_rd_in,       // read strobe
   output logic      [31:0]         reg_rdata_out,   // read data, next cycle
   // cpu access port
   input  wire logic                acc_req_in,      // first cycle of an access
   input  wire logic                acc_write_in,    // 1 write, 0 read
   input  wire logic [2:0]          acc_class_in,    // target register class
   input  wire logic                rx_buf_write_in, // reception writes buffer now
   input  wire logic                ext_fetch_in,    // fetch from external memory
   input  wire logic [6:0]          ext_credit_in,   // waits hidden by external fetch
   output logic                     cpu_hold_out,    // stall cpu pipeline
   output logic                     acc_ack_out,     // last cycle of access
   output logic      [6:0]          wait_count_out   // waits of latest access
);
   // ------------------------------------------------------------
   // reset release
   // ------------------------------------------------------------
   logic rst_meta_reg;
   logic rst_n;

   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rst_meta_reg <= 1'b0;
         rst_n        <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n        <= rst_meta_reg;
      end
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic [7:0]          sys_wait_reg;
   logic [3:0]          serial_ctl_reg;
   logic [PERIOD_W-1:0] scka_period_reg;
   logic [31:0]         rdata_reg;
   logic [6:0]          wait_count_reg;
   logic                busy;

   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         sys_wait_reg    <= wait_pkg::SYS_WAIT_RST;
         serial_ctl_reg  <= wait_pkg::SERIAL_CTL_RST;
         scka_period_reg <= PERIOD_W'(wait_pkg::SCKA_PER_RST);
      end else if (reg_wr_in) begin
         unique case (reg_addr_in)
            wait_pkg::ADDR_SYS_WAIT: begin
               sys_wait_reg <= reg_wdata_in[7:0];
            end
            wait_pkg::ADDR_SERIAL_CTL: begin
               serial_ctl_reg <= reg_wdata_in[3:0];
            end
            wait_pkg::ADDR_SCKA_PER: begin
               scka_period_reg <= reg_wdata_in[PERIOD_W-1:0];
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         rdata_reg <= '0;
      end else if (reg_rd_in) begin
         unique case (reg_addr_in)
            wait_pkg::ADDR_SYS_WAIT:   rdata_reg <= {24'h000000, sys_wait_reg};
            wait_pkg::ADDR_SERIAL_CTL: rdata_reg <= {28'h0000000, serial_ctl_reg};
            wait_pkg::ADDR_SCKA_PER:   rdata_reg <= 32'(scka_period_reg);
            wait_pkg::ADDR_STATUS:     rdata_reg <= {23'h000000, busy, 1'b0, wait_count_reg};
            default:                   rdata_reg <= '0;
         endcase
      end else begin
         rdata_reg <= '0;
      end
   end

   assign reg_rdata_out = rdata_reg;

   initial begin
      if (PERIOD_W < 5 || PERIOD_W > 24) begin
         $error("peripheral_access_wait_inserter: PERIOD_W out of range");
      end
   end

   // ------------------------------------------------------------
   // wait computation
   // ------------------------------------------------------------
   logic       m;
   logic [4:0] k_serial;
   logic [4:0] k_eff;
   logic [6:0] wait_max;
   logic [6:0] wait_load;
   logic [6:0] count_load;
   logic       start;

   // only 00h and 01h are legal settings; others act as 01h if bits 2:0 are nonzero, else as 00h
   assign m = (sys_wait_reg[2:0] != 3'h0); // see R01

   wait_factor_calc #(
      .PERIOD_W (PERIOD_W)
   ) u_factor (
      .scka_period_in (scka_period_reg),
      .m_in           (m),
      .conflict_in    (rx_buf_write_in),
      .k_out          (k_serial)
   );

   logic one_wait_case;
   assign one_wait_case = serial_ctl_reg[wait_pkg::CTL_CPU_MAIN]
      && {serial_ctl_reg[wait_pkg::CTL_SEL_HI_BIT], serial_ctl_reg[wait_pkg::CTL_SEL_LO_BIT]}
         == wait_pkg::SEL_MAIN_DIV1;

   always_comb begin
      k_eff    = 5'h00;
      wait_max = 7'h00;
      unique case (wait_pkg::access_class_t'(acc_class_in))
         wait_pkg::CLS_AUTO_SERIAL_BUF: begin
            if (acc_write_in) begin
               k_eff = k_serial; // see R05
            end
         end
         wait_pkg::CLS_TWO_WIRE_STATUS, wait_pkg::CLS_UART_RX_STATUS: begin
            if (!acc_write_in) begin
               k_eff = 5'h01; // see R08
            end
         end
         wait_pkg::CLS_REALTIME_BUF: begin
            if (acc_write_in && !serial_ctl_reg[wait_pkg::CTL_RT_ENABLE]) begin
               k_eff = 5'h01; // see R09
            end
         end
         default: begin
            k_eff = 5'h00;
         end
      endcase
      wait_max = 7'((wait_pkg::WAIT_BASE + int'(m)) * int'(k_eff)); // see R10
      if (wait_pkg::access_class_t'(acc_class_in) == wait_pkg::CLS_AUTO_SERIAL_BUF
          && acc_write_in && one_wait_case) begin
         wait_max = wait_pkg::WAIT_FIXED_1; // see R07
      end
   end

   // external fetch overlaps part of the wait, never adds to it
   assign wait_load = (ext_fetch_in && ext_credit_in < wait_max) ? wait_max - ext_credit_in
                    : (ext_fetch_in ? 7'h00 : wait_max); // see R03
   // cycles after the request cycle: 3+m+w total
   assign count_load = 7'(int'(wait_load) + wait_pkg::ACCESS_BASE - 2 + int'(m)); // see R10

   // ------------------------------------------------------------
   // access sequencing
   // ------------------------------------------------------------
   logic [6:0] cnt;
   logic       done;

   assign start = acc_req_in && !busy;

   wait_down_counter #(
      .CNT_W (7)
   ) u_counter (
      .clk_in   (sys_clk_in),
      .rst_n_in (rst_n),
      .load_in  (start),
      .value_in (count_load),
      .busy_out (busy),
      .cnt_out  (cnt),
      .done_out (done)
   );

   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         wait_count_reg <= 7'h00;
      end else if (start) begin
         wait_count_reg <= wait_load;
      end
   end

   // requests during an access are ignored: the cpu is stalled anyway
   assign cpu_hold_out   = start || (busy && cnt != 7'h00); // see R11
   assign acc_ack_out    = done; // see R12
   assign wait_count_out = wait_count_reg;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   logic [6:0] elapsed_reg;
   logic [6:0] total_reg;

   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         elapsed_reg <= 7'h00;
         total_reg   <= 7'h00;
      end else if (start) begin
         elapsed_reg <= 7'h01;
         total_reg   <= 7'(wait_pkg::ACCESS_BASE + int'(m) + int'(wait_load));
      end else if (busy) begin
         elapsed_reg <= elapsed_reg + 7'h01;
      end
   end

   property p_m_value;
      @(posedge sys_clk_in) disable iff (!rst_n)
         (sys_wait_reg == 8'h00 |-> !m) and (sys_wait_reg == 8'h01 |-> m);
   endproperty
   a_m_value: assert property (p_m_value) else $error("base wait m wrong"); // see R01

   property p_round;
      @(posedge sys_clk_in) disable iff (!rst_n)
         rx_buf_write_in && k_serial < wait_pkg::K_MAX_CONFL |->
            32'(k_serial) * 32'((2 + int'(m)) * 16) + 32'd16
               >= 32'(scka_period_reg) * 32'd5;
   endproperty
   a_round: assert property (p_round) else $error("fraction rounding wrong"); // see R02

   property p_ext_max;
      @(posedge sys_clk_in) disable iff (!rst_n)
         start |-> wait_load <= wait_max;
   endproperty
   a_ext_max: assert property (p_ext_max) else $error("external fetch raised waits"); // see R03

   property p_k_cont;
      @(posedge sys_clk_in) disable iff (!rst_n)
         !rx_buf_write_in |-> k_serial <= wait_pkg::K_MAX_CONT;
   endproperty
   a_k_cont: assert property (p_k_cont) else $error("continuous write factor above 18"); // see R05

   property p_k_confl;
      @(posedge sys_clk_in) disable iff (!rst_n)
         rx_buf_write_in |-> k_serial <= wait_pkg::K_MAX_CONFL;
   endproperty
   a_k_confl: assert property (p_k_confl) else $error("collision factor above 20"); // see R06

   property p_one_wait;
      @(posedge sys_clk_in) disable iff (!rst_n)
         start && one_wait_case && acc_write_in && !ext_fetch_in
         && acc_class_in == 3'(wait_pkg::CLS_AUTO_SERIAL_BUF) |=> wait_count_reg == 7'h01;
   endproperty
   a_one_wait: assert property (p_one_wait) else $error("serial buffer not one wait"); // see R07

   property p_status_read;
      @(posedge sys_clk_in) disable iff (!rst_n)
         start && !acc_write_in && !ext_fetch_in
         && (acc_class_in == 3'(wait_pkg::CLS_UART_RX_STATUS)
             || acc_class_in == 3'(wait_pkg::CLS_TWO_WIRE_STATUS))
         |=> wait_count_reg == 7'(2 + int'($past(m)));
   endproperty
   a_status_read: assert property (p_status_read) else $error("status read waits wrong"); // see R08

   property p_rt_write;
      @(posedge sys_clk_in) disable iff (!rst_n)
         start && acc_write_in && !ext_fetch_in
         && acc_class_in == 3'(wait_pkg::CLS_REALTIME_BUF)
         |=> wait_count_reg == ($past(serial_ctl_reg[wait_pkg::CTL_RT_ENABLE]) ? 7'h00
                                : 7'(2 + int'($past(m))));
   endproperty
   a_rt_write: assert property (p_rt_write) else $error("realtime buffer waits wrong"); // see R09

   property p_length;
      @(posedge sys_clk_in) disable iff (!rst_n)
         acc_ack_out |-> elapsed_reg + 7'h01 == total_reg;
   endproperty
   a_length: assert property (p_length) else $error("access length wrong"); // see R10

   property p_hold;
      @(posedge sys_clk_in) disable iff (!rst_n)
         start |=> (cpu_hold_out && !acc_ack_out) [*1] ##0 1'b1 or acc_ack_out;
   endproperty
   a_hold: assert property (p_hold) else $error("cpu released early"); // see R11

   property p_release;
      @(posedge sys_clk_in) disable iff (!rst_n)
         acc_ack_out |=> !busy;
   endproperty
   a_release: assert property (p_release) else $error("bus not released after ack"); // see R12

   property p_hold_busy;
      @(posedge sys_clk_in) disable iff (!rst_n)
         busy && !acc_ack_out |-> cpu_hold_out;
   endproperty
   a_hold_busy: assert property (p_hold_busy) else $error("cpu not held during wait"); // see R11
endmodule
`default_nettype wire

// ==== tb/cpu_access_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module cpu_access_model (
   input  wire logic       clk_in,        // cpu clock
   input  wire logic       hold_in,       // stall from the inserter
   input  wire logic       ack_in,        // last cycle of access
   output logic            req_out,       // first cycle of access
   output logic            write_out,     // 1 write, 0 read
   output logic      [2:0] class_out,     // target register class
   output logic            rx_write_out,  // reception writes buffer
   output logic            ext_fetch_out, // fetch from external memory
   output logic      [6:0] credit_out     // waits hidden by fetch
);
   initial begin
      req_out       = 1'b0;
      write_out     = 1'b0;
      class_out     = 3'h0;
      rx_write_out  = 1'b0;
      ext_fetch_out = 1'b0;
      credit_out    = 7'h00;
   end

   // ------------------------------------------------------------
   // one access: called and returning at a rising edge
   // ------------------------------------------------------------
   // the bench clears the cpu main-clock bit in several tests, but the inserter
   // models no subclock wait, so no access can land in the unrecoverable one
   task automatic access(input logic [2:0] c, input logic w, input logic x,
                         input logic e, input logic [6:0] cr, input int gap);
      int n;
      begin
         n = 0;
         req_out       <= 1'b1;
         write_out     <= w;
         class_out     <= c;
         rx_write_out  <= x;
         ext_fetch_out <= e;
         credit_out    <= cr;
         @(posedge clk_in);
         // qualifiers only count with the request: flip write, class and reception write
         req_out      <= 1'b0;
         write_out    <= ~w;
         class_out    <= ~c;
         rx_write_out <= ~x;
         // stay on this access until the last cycle
         do begin
            @(posedge clk_in);
            n++;
         end while ((hold_in === 1'b1 || ack_in !== 1'b1) && n < 300);
         repeat (gap) @(posedge clk_in);
      end
   endtask
endmodule
`default_nettype wire

// ==== tb/peripheral_access_wait_inserter_bench.sv ====
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin mismatches++; $display("FAIL %s expected %0h seen %0h", nm, e, g); end end
module peripheral_access_wait_inserter_bench;
   typedef struct {int cyc; logic [6:0] w;} note_t;
   logic        sys_clk, arst_n, wr, rd, req, acc_wr, rxw, ext, hold, ack;
   logic [7:0]  addr;
   logic [31:0] wdata, rdata;
   logic [2:0]  cls;
   logic [6:0]  credit, wcnt;
   int          mismatches, checks_done, cycles, cnt, holds;
   integer      seed;
   logic        rd_seen, act, m_now;
   logic [3:0]  ctl_now;
   logic [11:0] per_now;
   note_t       acc_q[$];
   logic [31:0] rd_q[$];

   peripheral_access_wait_inserter #(.PERIOD_W(12)) peripheral_access_wait_inserter_i (
      .sys_clk_in(sys_clk), .arst_n_in(arst_n), .reg_addr_in(addr), .reg_wdata_in(wdata),
      .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .acc_req_in(req),
      .acc_write_in(acc_wr), .acc_class_in(cls), .rx_buf_write_in(rxw), .ext_fetch_in(ext),
      .ext_credit_in(credit), .cpu_hold_out(hold), .acc_ack_out(ack), .wait_count_out(wcnt));

   cpu_access_model cpu_access_model_i (
      .clk_in(sys_clk), .hold_in(hold), .ack_in(ack), .req_out(req), .write_out(acc_wr),
      .class_out(cls), .rx_write_out(rxw), .ext_fetch_out(ext), .credit_out(credit));

   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   // ------------------------------------------------------------
   // expected waits, from the bench's own copy of the settings
   // ------------------------------------------------------------
   function automatic logic [6:0] exp_wait(logic [2:0] c, logic w, logic x, logic e,
                                           logic [6:0] cr);
      int m, num, den, k, wt;
      begin
         m = m_now;
         den = (2 + m) * 16;
         num = 5 * int'(per_now) - (x ? 0 : (4 + m) * 16);
         k = 0;
         wt = 0;
         if (num > 0) begin
            k = num / den;
            if ((num % den) * (2 + m) > den) k++;
         end
         if (k > (x ? 20 : 18)) k = x ? 20 : 18;
         case (c)
            3'h1: if (w) wt = (ctl_now[2] && ctl_now[1:0] == 2'h0) ? 1 : (2 + m) * k;
            3'h2, 3'h3: if (!w) wt = 2 + m;
            3'h4: if (w && !ctl_now[3]) wt = 2 + m;
            default: wt = 0;
         endcase
         if (e) wt = (wt > int'(cr)) ? wt - int'(cr) : 0;
         return wt[6:0];
      end
   endfunction

   task automatic do_acc(logic [2:0] c, logic w, logic x, logic e, logic [6:0] cr, int gap);
      logic [6:0] wt;
      begin
         wt = exp_wait(c, w, x, e, cr);
         acc_q.push_back('{2 + int'(m_now) + int'(wt), wt});
         cpu_access_model_i.access(c, w, x, e, cr, gap);
      end
   endtask

   task automatic reg_write(logic [7:0] a, logic [31:0] d);
      begin
         if (a == wait_pkg::ADDR_SYS_WAIT) m_now = (d[2:0] != 3'h0);
         if (a == wait_pkg::ADDR_SERIAL_CTL) ctl_now = d[3:0];
         if (a == wait_pkg::ADDR_SCKA_PER) per_now = d[11:0];
         addr  <= a;
         wdata <= d;
         wr    <= 1'b1;
         @(posedge sys_clk);
         wr <= 1'b0;
         @(posedge sys_clk);
      end
   endtask

   task automatic reg_read(logic [7:0] a, logic [31:0] d);
      begin
         rd_q.push_back(d);
         addr <= a;
         rd   <= 1'b1;
         @(posedge sys_clk);
         rd <= 1'b0;
         @(posedge sys_clk);
      end
   endtask

   task automatic test_end(string nm);
      $display("test %s done", nm);
   endtask

   task automatic end_of_test();
      begin
         $display("checks %0d mismatches %0d", checks_done, mismatches);
         if (mismatches == 0 && checks_done > 0)
            $display("Finished cleanly");
         else
            $display("Finished with errors");
         $finish;
      end
   endtask

   // ------------------------------------------------------------
   // monitor: takes the oldest note when a result shows
   // ------------------------------------------------------------
   always @(posedge sys_clk) begin
      logic [31:0] er;
      note_t       n;
      if (rd_seen === 1'b1 && rd_q.size() > 0) begin
         er = rd_q.pop_front();
         `CHK("read data", er, rdata)
      end
      rd_seen = rd;
      if (req === 1'b1 && !act) begin
         act = 1'b1;
         cnt = 0;
         holds = 0;
      end else if (act) cnt++;
      if (act && ack !== 1'b1 && hold === 1'b1) holds++;
      if (act && ack === 1'b1 && acc_q.size() > 0) begin
         n = acc_q.pop_front();
         `CHK("ack cycle", n.cyc, cnt)
         `CHK("hold cycles", n.cyc, holds)
         `CHK("hold at ack", 1'b0, hold)
         `CHK("wait count", n.w, wcnt)
         act = 1'b0;
      end
      cycles++;
      // about twenty times the expected length of the run
      if (cycles == 20000) begin
         mismatches++;
         end_of_test();
      end
   end

   initial begin
      logic [11:0] pers [4];
      logic [31:0] r;
      seed = 32'hc316cf7a;
      pers = '{12'h014, 12'h018, 12'h100, 12'h000};
      {arst_n, wr, rd, addr, wdata, rd_seen, act} = '0;
      {mismatches, checks_done, cycles, cnt, holds} = '0;
      m_now = 1'b1;
      ctl_now = wait_pkg::SERIAL_CTL_RST;
      per_now = wait_pkg::SCKA_PER_RST;
      repeat (20) @(posedge sys_clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      reg_read(wait_pkg::ADDR_SYS_WAIT, 32'h77);
      reg_read(wait_pkg::ADDR_SERIAL_CTL, 32'h0);
      reg_read(wait_pkg::ADDR_SCKA_PER, 32'h10);
      reg_read(8'h10, 32'h0);
      test_end("reset values");
      do_acc(3'h3, 1'b0, 1'b0, 1'b0, 7'h00, 0);
      reg_read(wait_pkg::ADDR_STATUS, 32'h3);
      do_acc(3'h2, 1'b0, 1'b0, 1'b0, 7'h00, 0);
      do_acc(3'h3, 1'b1, 1'b0, 1'b0, 7'h00, 0);
      do_acc(3'h3, 1'b0, 1'b0, 1'b1, 7'h02, 2);
      do_acc(3'h2, 1'b0, 1'b0, 1'b1, 7'h05, 0);
      do_acc(3'h0, 1'b1, 1'b0, 1'b0, 7'h00, 0);
      test_end("status reads");
      for (int i = 0; i < 2; i++) begin
         reg_write(wait_pkg::ADDR_SYS_WAIT, 32'(1 - i));
         do_acc(3'h3, 1'b0, 1'b0, 1'b0, 7'h00, 0);
         reg_write(wait_pkg::ADDR_SERIAL_CTL, 32'(i * 8));
         do_acc(3'h4, 1'b1, 1'b0, 1'b0, 7'h00, 1);
         do_acc(3'h4, 1'b0, 1'b0, 1'b0, 7'h00, 0);
      end
      test_end("base wait and realtime");
      reg_write(wait_pkg::ADDR_SERIAL_CTL, 32'h4);
      do_acc(3'h1, 1'b1, 1'b0, 1'b0, 7'h00, 0);
      do_acc(3'h1, 1'b1, 1'b1, 1'b0, 7'h00, 0);
      reg_write(wait_pkg::ADDR_SERIAL_CTL, 32'h5);
      foreach (pers[i]) begin
         reg_write(wait_pkg::ADDR_SCKA_PER, {20'h0, pers[i]});
         do_acc(3'h1, 1'b1, 1'b0, 1'b0, 7'h00, 0);
         do_acc(3'h1, 1'b1, 1'b1, 1'b0, 7'h00, 0);
      end
      test_end("serial buffer table");
      for (int i = 0; i < 12; i++) begin
         r = $random(seed);
         reg_write(wait_pkg::ADDR_SYS_WAIT, {29'h0, r[2:0]});
         reg_write(wait_pkg::ADDR_SCKA_PER, {23'h0, r[16:8]});
         reg_write(wait_pkg::ADDR_SERIAL_CTL, {29'h0, r[20], r[19:18]});
         do_acc(3'h1, 1'b1, r[21], r[22], {2'h0, r[27:23]}, int'(r[29:28]));
      end
      test_end("random serial writes");
      // let the monitor take the last ack before the verdict
      repeat (2) @(posedge sys_clk);
      `CHK("notes left", 0, acc_q.size() + rd_q.size())
      end_of_test();
   end
endmodule
`default_nettype wire
